// *** bench/sps_board_model.sv ***
/*
 * Board side of the status pins: one strap resistor on each pin and the
 * external monitor that sees the resolved pin level.
 * Assumes the block drives a pin only while its output enable is high.
 */
`timescale 1ns/100ps
`default_nettype none

module sps_board_model
  import sps_pkg::*;
(
  input wire logic [STRAP_W-1:0] pull,
  input wire logic [STRAP_W-1:0] pins_out,
  input wire logic [STRAP_W-1:0] pins_oe,
  output logic [STRAP_W-1:0] pins_lvl
);
  ////////////////////////////////////////////////////////////////////////////
  // A released pin falls to its resistor level, so the strap is what is seen.
  always_comb begin
    for (int i = 0; i < STRAP_W; i++) begin
      pins_lvl[i] = pins_oe[i] ? pins_out[i] : pull[i];
    end
  end
endmodule : sps_board_model

`default_nettype wire

// *** bench/tb_top.sv ***
/*
 * Self-checking bench for the status pin and strap block over AXI4-Lite.
 * Assumes the board model resolves the pins and all stimulus moves on mclk.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end

module tb_top
  import sps_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, flags = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [3:0] pull = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, sysclk_direct_mode;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp, rresp;
  logic [31:0] s_axi_rdata, rdv;
  logic [3:0] pins_out, pins_oe, pins_lvl;
  logic [TW_W-1:0] tune;
  logic [MULT_W-1:0] mult;
  logic [7:0] tc [9] = '{8'h01, 8'h01, 8'h05, 8'h07, 8'h07, 8'h08, 8'h40, 8'h40, 8'h00};
  logic [7:0] tf [9] = '{8'h01, 8'h02, 8'h02, 8'h08, 8'h05, 8'h10, 8'h80, 8'h70, 8'hFF};
  logic [8:0] te = 9'h06D;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  sps_status_strap #(.NUM_PINS(4)) sps_status_strap_i (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .reference_lost_flag(flags[1:0]), .frequency_out_of_limits_flag(flags[3:2]),
    .aux_status_flag(flags[7:4]), .status_strap_pins_in(pins_lvl), .status_strap_pins_out(pins_out),
    .status_strap_pins_oe(pins_oe), .active_tuning_word(tune), .sysclk_direct_mode,
    .sysclk_mult_factor(mult), .irq);

  sps_board_model sps_board_model_i (.pull(pull), .pins_out(pins_out), .pins_oe(pins_oe), .pins_lvl(pins_lvl));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling that cuts a hang short.
  always #5 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end

  // Prints the verdict and ends the run.
  task automatic summarize;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // Waits n rising edges and returns at the following falling edge.
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : step

  // One AXI4-Lite write; each channel drops when its ready is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ap, wp, ah, wh, bh;
    ap = 1'b1;
    wp = 1'b1;
    bh = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (ap || wp) begin
      @(negedge mclk);
      ah = ap && s_axi_awready;
      wh = wp && s_axi_wready;
      @(posedge mclk);
      if (ah) begin
        s_axi_awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (wh) begin
        s_axi_wvalid <= 1'b0;
        wp = 1'b0;
      end
    end
    while (!bh) begin
      @(negedge mclk);
      bh = s_axi_bvalid;
      bresp = s_axi_bresp;
      @(posedge mclk);
    end
    s_axi_bready <= 1'b0;
  endtask : wr

  // One AXI4-Lite read; data and response are taken at the falling edge before the handshake edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ah, rh;
    ah = 1'b0;
    rh = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!ah) begin
      @(negedge mclk);
      ah = s_axi_arready;
      @(posedge mclk);
    end
    s_axi_arvalid <= 1'b0;
    while (!rh) begin
      @(negedge mclk);
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      rresp = s_axi_rresp;
      @(posedge mclk);
    end
    s_axi_rready <= 1'b0;
  endtask : rd

  // Reads a register and compares it.
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHECK(nm, e, d)
  endtask : rchk

  // Reset with a strap pattern, then check what the capture loaded.
  task automatic rst(input logic [3:0] c);
    @(posedge mclk);
    nrst <= 1'b0;
    pull <= c;
    step(5);
    `CHECK("oe_in_reset", 4'h0, pins_oe)
    @(posedge mclk);
    nrst <= 1'b1;
    step(2);
    `CHECK("oe_after", 4'hF, pins_oe)
    `CHECK("tune", TUNE_WORDS[c[2:0]], tune)
    `CHECK("direct", c[3], sysclk_direct_mode)
    `CHECK("mult", (c[3] ? MULT_DIRECT : 6'h28), mult)
    rchk("strap", OFF_STRAP, {27'h0, c[3], c});
  endtask : rst

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: strap codes, bus refusals, pin selection, interrupt.
  initial begin
    for (int c = 0; c < 16; c++) begin
      rst(c[3:0]);
    end
    rd(8'h28, rdv);
    `CHECK("unmapped_resp", RESP_SLVERR, rresp)
    `CHECK("unmapped_data", 32'h0, rdv)
    wr(OFF_STRAP, 32'h0000_0000);
    `CHECK("ro_resp", RESP_OKAY, bresp)
    rchk("strap_kept", OFF_STRAP, 32'h0000_001F);
    for (int i = 0; i < 9; i++) begin
      wr(OFF_PIN_CFG0 + 8'(4 * (i % 4)), {24'h0, tc[i]});
      @(posedge mclk);
      flags <= tf[i];
      step(2);
      `CHECK("pin_value", te[i], pins_out[i % 4])
      rchk("live_flags", OFF_FLAG_LIVE, {24'h0, tf[i]});
    end
    @(posedge mclk);
    flags <= 8'h00;
    step(2);
    wr(OFF_EVT_STAT, 32'h0000_00FF);
    wr(OFF_EVT_MASK, 32'h0000_0001);
    wr(OFF_PIN_CFG0, 32'h0000_0080);
    step(1);
    `CHECK("irq_idle", 1'b0, irq)
    @(posedge mclk);
    flags <= 8'h01;
    step(3);
    `CHECK("irq_set", 1'b1, irq)
    `CHECK("irq_pin", 1'b1, pins_out[0])
    rchk("evt_stat", OFF_EVT_STAT, 32'h0000_0001);
    wr(OFF_EVT_STAT, 32'h0000_0001);
    step(2);
    `CHECK("irq_clr", 1'b0, irq)
    `CHECK("irq_pin_clr", 1'b0, pins_out[0])
    wr(OFF_EVT_MASK, 32'h0000_0000);
    @(posedge mclk);
    flags <= 8'h00;
    step(3);
    `CHECK("irq_masked", 1'b0, irq)
    rchk("evt_masked", OFF_EVT_STAT, 32'h0000_0001);
    // Software may still override the strapped word and factor.
    wr(OFF_TUNE, 32'h0000_ABCD);
    rchk("tune_rd", OFF_TUNE, 32'h0000_ABCD);
    `CHECK("tune_out", 16'hABCD, tune)
    wr(OFF_MULT, 32'h0000_0014);
    rchk("mult_rd", OFF_MULT, 32'h0000_0014);
    `CHECK("mult_out", 6'h14, mult)
    summarize();
  end
endmodule : tb_top

`default_nettype wire

// *** verilog/sps_pin_mux.sv ***
/*
 * Output selection for one status pin: OR of enabled flags or the interrupt.
 * Assumes flags are synchronous to the block clock.
 */
`timescale 1ns/100ps
`default_nettype none

module sps_pin_mux
  import sps_pkg::*;
(
  input wire logic [CFG_W-1:0] cfg,
  input wire logic [FLAG_W-1:0] flags,
  input wire logic irq,
  output logic val
);

  logic lost_sel;
  logic limit_sel;
  logic combo;

  // Reference flags of the one chosen reference only.
  assign lost_sel = cfg[CFG_REF_SEL] ? flags[FLG_LOST_LSB + 1] : flags[FLG_LOST_LSB];
  assign limit_sel = cfg[CFG_REF_SEL] ? flags[FLG_LIMIT_LSB + 1] : flags[FLG_LIMIT_LSB];

  // OR of every enabled indication; nothing enabled gives low.
  assign combo = (cfg[CFG_LOST] & lost_sel) | (cfg[CFG_LIMIT] & limit_sel) |
    (|(cfg[CFG_AUX_LSB +: AUX_W] & flags[FLG_AUX_LSB +: AUX_W]));

  // Interrupt selection replaces the status combination.
  assign val = cfg[CFG_IRQ] ? irq : combo;

endmodule : sps_pin_mux

`default_nettype wire

// *** verilog/sps_pkg.sv ***
/*
 * Constants shared by the status pin and startup strap block: field layouts,
 * register offsets, reset values and the preset tuning words.
 * Assumes a 32-bit AXI4-Lite register bus and four strap capable pins.
 */
`default_nettype none

package sps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int STRAP_W = 4;
  localparam int FLAG_W = 8;
  localparam int CFG_W = 8;
  localparam int TW_W = 16;
  localparam int MULT_W = 6;
  localparam int ROM_AW = 3;
  localparam int ADDR_W = 8;

  // Pin control field positions.
  localparam int CFG_LOST = 0;
  localparam int CFG_LIMIT = 1;
  localparam int CFG_REF_SEL = 2;
  localparam int CFG_AUX_LSB = 3;
  localparam int CFG_IRQ = 7;
  localparam int AUX_W = 4;

  // Live flag vector positions; bit 0 of each pair is reference_a.
  localparam int FLG_LOST_LSB = 0;
  localparam int FLG_LIMIT_LSB = 2;
  localparam int FLG_AUX_LSB = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_PIN_CFG0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAG_LIVE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EVT_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STRAP = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_TUNE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_MULT = 8'h24;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values.
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
  localparam logic [FLAG_W-1:0] MASK_RST = 8'h00;
  localparam logic [TW_W-1:0] TUNE_RST = 16'h0000;
  localparam logic [MULT_W-1:0] MULT_XTAL = 6'h28;
  localparam logic [MULT_W-1:0] MULT_DIRECT = 6'h01;

  // Preset tuning words, entry 7 first; word / 2^16 times the sample clock.
  localparam logic [7:0][TW_W-1:0] TUNE_WORDS = {
    16'h27D0, 16'h1F75, 16'h1797, 16'h13E8,
    16'h0FBA, 16'h0D45, 16'h09F4, 16'h0000
  };

endpackage : sps_pkg

`default_nettype wire

// *** verilog/sps_status_strap.sv ***
/*
 * Status pins with startup strap capture, tuning word preset, event
 * interrupt and an AXI4-Lite register slave.
 * Assumes all inputs are synchronous to mclk and that nrst covers both the
 * power-up pulse and the manual reset pin; the board pulls the pins.
 */
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module sps_status_strap
  import sps_pkg::*;
#(
  parameter int NUM_PINS = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] reference_lost_flag,
  input wire logic [1:0] frequency_out_of_limits_flag,
  input wire logic [AUX_W-1:0] aux_status_flag,
  input wire logic [STRAP_W-1:0] status_strap_pins_in,
  output logic [STRAP_W-1:0] status_strap_pins_out,
  output logic [STRAP_W-1:0] status_strap_pins_oe,
  output logic [TW_W-1:0] active_tuning_word,
  output logic sysclk_direct_mode,
  output logic [MULT_W-1:0] sysclk_mult_factor,
  output logic irq
);

  if (NUM_PINS != STRAP_W) begin : g_chk
    $error("NUM_PINS must equal the strap width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [CFG_W-1:0] cfg_r [NUM_PINS];
  logic [CFG_W-1:0] cfg_nxt [NUM_PINS];
  logic [FLAG_W-1:0] flags, ev, w1c;
  logic [FLAG_W-1:0] prev_r, prev_nxt, evst_r, evst_nxt, mask_r, mask_nxt;
  logic [STRAP_W-1:0] strap_r, strap_nxt, pout_r, pout_nxt, poe_r, poe_nxt;
  logic [STRAP_W-1:0] pin_val;
  logic pend_r, pend_nxt, direct_r, direct_nxt, irq_r, irq_nxt;
  logic [TW_W-1:0] tune_r, tune_nxt, rom_word, wmask;
  logic [MULT_W-1:0] mult_r, mult_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, rd_val;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic wr_do, wr_ok, rd_ok;

  // Live indications in one vector.
  assign flags = {aux_status_flag, frequency_out_of_limits_flag, reference_lost_flag};

  ////////////////////////////////////////////////////////////////////////////
  // Per pin selection, each pin reading only its own control byte.
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    sps_pin_mux u_mux (
      .cfg(cfg_r[i]),
      .flags(flags),
      .irq(irq_r),
      .val(pin_val[i])
    );
  end

  // Preset word for the levels currently on the strap pins.
  sps_tune_rom u_rom (
    .addr(status_strap_pins_in[ROM_AW-1:0]),
    .word(rom_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes: one write and one read in flight, channels taken apart.
  assign wr_do = aw_have_r && w_have_r && !bvalid_r;
  assign wr_ok = (waddr_r <= OFF_MULT) && (waddr_r[1:0] == 2'h0);
  assign rd_ok = (s_axi_araddr <= OFF_MULT) && (s_axi_araddr[1:0] == 2'h0);

  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    arready_nxt = arready_r;
    if (s_axi_awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      waddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (wr_do) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_val;
      rresp_nxt = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt = !w_have_nxt && !bvalid_nxt;
  end

  // Read data selection; unmapped words read as zero.
  always_comb begin
    rd_val = 32'h0000_0000;
    if (s_axi_araddr < OFF_FLAG_LIVE) begin
      rd_val[CFG_W-1:0] = cfg_r[s_axi_araddr[3:2]];
    end else if (rd_ok) begin
      case (s_axi_araddr)
        OFF_FLAG_LIVE: rd_val[FLAG_W-1:0] = flags;
        OFF_EVT_STAT: rd_val[FLAG_W-1:0] = evst_r;
        OFF_EVT_MASK: rd_val[FLAG_W-1:0] = mask_r;
        OFF_STRAP: rd_val[STRAP_W:0] = {direct_r, strap_r};
        OFF_TUNE: rd_val[TW_W-1:0] = tune_r;
        OFF_MULT: rd_val[MULT_W-1:0] = mult_r;
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file, strap capture, events and pin drive.
  assign wmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  always_comb begin
    cfg_nxt = cfg_r;
    mask_nxt = mask_r;
    tune_nxt = tune_r;
    mult_nxt = mult_r;
    strap_nxt = strap_r;
    direct_nxt = direct_r;
    pend_nxt = pend_r;
    poe_nxt = poe_r;
    w1c = '0;
    if (wr_do && wr_ok && wstrb_r[0]) begin
      if (waddr_r < OFF_FLAG_LIVE) begin
        cfg_nxt[waddr_r[3:2]] = wdata_r[CFG_W-1:0];
      end else if (waddr_r == OFF_EVT_MASK) begin
        mask_nxt = wdata_r[FLAG_W-1:0];
      end else if (waddr_r == OFF_EVT_STAT) begin
        w1c = wdata_r[FLAG_W-1:0];
      end else if (waddr_r == OFF_MULT) begin
        mult_nxt = wdata_r[MULT_W-1:0];
      end
    end
    if (wr_do && waddr_r == OFF_TUNE) begin
      tune_nxt = (tune_r & ~wmask) | (wdata_r[TW_W-1:0] & wmask);
    end
    // First edge after any reset release: sample straps, preset, drive pins.
    if (pend_r) begin
      strap_nxt = status_strap_pins_in;
      tune_nxt = rom_word;
      direct_nxt = status_strap_pins_in[STRAP_W-1];
      mult_nxt = status_strap_pins_in[STRAP_W-1] ? MULT_DIRECT : MULT_XTAL;
      pend_nxt = 1'b0;
      poe_nxt = '1;
    end
    // Any change of a live flag is an event, except across the capture edge.
    prev_nxt = flags;
    ev = pend_r ? '0 : (flags ^ prev_r);
    evst_nxt = (evst_r & ~w1c) | ev; // Set wins over clear.
    irq_nxt = |(evst_r & mask_r);
    pout_nxt = pend_r ? '0 : pin_val;
  end

  // Reset floats the pins at once and arms the capture edge.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        cfg_r[i] <= CFG_RST;
      end
      mask_r <= MASK_RST;
      evst_r <= '0;
      prev_r <= '0;
      tune_r <= TUNE_RST;
      mult_r <= MULT_XTAL;
      strap_r <= '0;
      direct_r <= 1'b0;
      pend_r <= 1'b1;
      poe_r <= '0;
      pout_r <= '0;
      irq_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bresp_r <= RESP_OKAY;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      cfg_r <= cfg_nxt;
      mask_r <= mask_nxt;
      evst_r <= evst_nxt;
      prev_r <= prev_nxt;
      tune_r <= tune_nxt;
      mult_r <= mult_nxt;
      strap_r <= strap_nxt;
      direct_r <= direct_nxt;
      pend_r <= pend_nxt;
      poe_r <= poe_nxt;
      pout_r <= pout_nxt;
      irq_r <= irq_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bresp_r <= bresp_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Outputs straight from flip-flops.
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign status_strap_pins_out = pout_r;
  assign status_strap_pins_oe = poe_r;
  assign active_tuning_word = tune_r;
  assign sysclk_direct_mode = direct_r;
  assign sysclk_mult_factor = mult_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the design's own behaviour.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // Pins float while the capture edge is still pending.
  a_float_pending: assert property (pend_r |-> poe_r == '0)
    else $error("pins driven before strap capture");

  // The strap register holds the pin levels of the capture edge.
  a_strap_capture: assert property ($fell(pend_r) |-> strap_r == $past(status_strap_pins_in))
    else $error("strap register differs from sampled pins");

  // All pins drive again right after capture and still drive one cycle later.
  a_drive_after: assert property ($fell(pend_r) |-> poe_r == '1 ##1 poe_r == '1)
    else $error("pins not returned to output mode");

  // Strap code one loads the first nonzero preset word.
  a_rom_preset: assert property ($fell(pend_r) && strap_r[2:0] == 3'h1 |-> tune_r == 16'h09F4)
    else $error("wrong preset tuning word");

  // Clock mode follows strap bit 3, with a factor of 40 in crystal mode.
  a_mode_select: assert property ($fell(pend_r) |-> direct_r == strap_r[3] &&
    (strap_r[3] || mult_r == 6'h28))
    else $error("clock mode or factor wrong after capture");

  // An unmasked flag change raises the interrupt within two cycles.
  a_irq_raise: assert property (!pend_r && ((flags ^ prev_r) & mask_r) != '0 && w1c == '0 |-> ##[1:2] irq_r)
    else $error("unmasked event did not raise interrupt");

  // A pin set to the interrupt follows the interrupt flag.
  a_pin_irq: assert property (!pend_r && cfg_r[0][CFG_IRQ] |=> pout_r[0] == $past(irq_r))
    else $error("pin does not follow interrupt flag");

  // A pin with nothing selected stays low.
  a_pin_quiet: assert property (!pend_r && cfg_r[1] == CFG_RST |=> !pout_r[1])
    else $error("unselected pin driven high");

  // Reference b selection ignores reference a flags.
  a_ref_isolate: assert property (!pend_r && cfg_r[0] == 8'h07 && flags[7:4] == 4'h0 && !flags[1] && !flags[3] |=>
    !pout_r[0])
    else $error("reference a flag leaked to reference b pin");

  // Either lost or limits flag of reference b asserts the pin.
  a_ref_either: assert property (!pend_r && cfg_r[3] == 8'h07 && (flags[1] || flags[3]) |=> pout_r[3])
    else $error("lost or limits flag missed");

  c_capture: cover property ($fell(pend_r) && strap_r == 4'hF);
  c_irq: cover property ($rose(irq_r));
  c_pin_high: cover property (!pend_r && pout_r[0]);
  c_write: cover property (wr_do && waddr_r == OFF_TUNE);

endmodule : sps_status_strap

`default_nettype wire

// *** verilog/sps_tune_rom.sv ***
/*
 * Preset tuning word ROM, eight entries of sixteen bits.
 * Assumes the address is stable in the cycle the word is loaded.
 */
`timescale 1ns/100ps
`default_nettype none

module sps_tune_rom
  import sps_pkg::*;
(
  input wire logic [ROM_AW-1:0] addr,
  output logic [TW_W-1:0] word
);

  logic [TW_W-1:0] rom [8];

  // Table built from the shared constants, one entry per strap code.
  for (genvar i = 0; i < 8; i++) begin : g_rom
    assign rom[i] = TUNE_WORDS[i];
  end

  // Lookup of the selected entry.
  assign word = rom[addr];

endmodule : sps_tune_rom

`default_nettype wire
